// >>> common/sac_pkg.sv
// Purpose: shared constants and types for the servo alarm code output block
// Assumes: one 50 MHz clock, discrete inputs already synchronous
// Notes:   alarm sources arrive as a vector of raw cause levels

// ****************************************
// package
// ****************************************
package sac_pkg;

    localparam int unsigned CLK_HZ        = 50_000_000;
    localparam int unsigned N_ALARMS      = 23;
    localparam int unsigned N_WARNINGS    = 4;
    localparam int unsigned CODE_W        = 3;
    localparam int unsigned TRQ_W         = 12;
    localparam int unsigned SPD_W         = 12;
    localparam int unsigned N_SPD_LIM     = 7;

    // output-function selector value that routes the alarm code to the status pins
    localparam logic [15:0] OUTFN_CODE_SEL = 16'hDDD1;

    // clear-method flags per alarm
    localparam logic [2:0]  CLR_POWER     = 3'h1;
    localparam logic [2:0]  CLR_KEY       = 3'h2;
    localparam logic [2:0]  CLR_INPUT     = 3'h4;

    localparam logic [CODE_W-1:0] CODE_RST = 3'h0;

    // 3-bit pin patterns per alarm, index order matches i_alarm_cause
    localparam logic [N_ALARMS*CODE_W-1:0] ALARM_CODES = {
        3'h0, 3'h0, 3'h0, 3'h3, 3'h3, 3'h3, 3'h3, 3'h0, 3'h2, 3'h4,
        3'h6, 3'h2, 3'h4, 3'h2, 3'h4, 3'h3, 3'h0, 3'h5, 3'h0, 3'h0,
        3'h0, 3'h0, 3'h2
    };
    // allowed clear methods per alarm, same index order
    localparam logic [N_ALARMS*3-1:0] ALARM_CLR = {
        3'h1, 3'h7, 3'h7, 3'h1, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7, 3'h1,
        3'h1, 3'h7, 3'h7, 3'h7, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1, 3'h1,
        3'h1, 3'h1, 3'h7
    };

    typedef enum logic [1:0] {
        SAC_ST_OFF   = 2'b00,
        SAC_ST_RUN   = 2'b01,
        SAC_ST_FAULT = 2'b10
    } sac_state_t;

    typedef struct packed {
        logic zero_speed;
        logic ready;
        logic speed_reached;
    } sac_status_t;

    typedef struct packed {
        logic [TRQ_W-1:0] torque_cmd;
        logic             motor_free;
        logic             rotate_en;
    } sac_drive_t;

endpackage

// >>> verilog/sac_latch.sv
// Purpose: latches each alarm cause until an allowed clear arrives
// Assumes: cause levels synchronous to i_clk
// Notes:   warnings pass through unlatched so they self-clear

module sac_latch import sac_pkg::*; #(
    parameter int unsigned N = N_ALARMS
) (
    // clock and reset
    input  wire logic         i_clk,
    input  wire logic         i_rstn,
    // causes and clear requests
    input  wire logic [N-1:0] i_cause,
    input  wire logic         i_clr_key,
    input  wire logic         i_clr_input,
    // latched alarms
    output logic      [N-1:0] o_latched
);

    if (N != N_ALARMS) begin : size_check_g
        $error("sac_latch: N must equal N_ALARMS");
    end

    typedef struct packed {
        logic [N-1:0] lat;
    } sac_latch_st_t;

    sac_latch_st_t st_reg;
    sac_latch_st_t st_next;

    function automatic logic clr_ok(input int unsigned idx, input logic key, input logic inp);
        logic [2:0] m;
        m = ALARM_CLR[idx*3 +: 3];
        return (key && (m & CLR_KEY) != 3'h0) || (inp && (m & CLR_INPUT) != 3'h0);
    endfunction

    always_comb begin
        st_next = st_reg;
        for (int unsigned k = 0; k < N; k++) begin
            // a live cause wins over any clear; clearing needs the cause gone
            if (i_cause[k]) begin
                st_next.lat[k] = 1'b1;
            end else if (clr_ok(k, i_clr_key, i_clr_input)) begin
                st_next.lat[k] = 1'b0;
            end
        end
    end

    // power cycling is the reset itself
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign o_latched = st_reg.lat;

endmodule

// >>> verilog/sac_top.sv
// What this block does
// - any alarm turns the fault output off (open).
// - alarm code on status pins only when output function selects it.
// - warnings never put a code on the status pins.
// - no alarm: pins show zero-speed, ready, speed-reached status.
// - alarm clears only after cause gone, by its allowed methods.
// - drive enable off leaves the motor shaft free.
// - zero analog torque command gives no rotation.
// - selected speed limit caps speed; zero limit blocks rotation.
// - torque limit 1 caps torque; zero blocks rotation.
// - analog torque command scaled by maximum-output setting.
// - warnings clear themselves once their cause is removed.
//
// Purpose: torque-mode start gating and alarm signalling
// Assumes: all inputs synchronous to i_clk, 50 MHz
// Notes:   lowest-index active alarm chooses the code
//          fault output high means the output is closed (no alarm)
//          the torque path is a product, shift and clamp to torque limit 1, with no filtering
//          start inputs are levels; both on counts as no start

module sac_top import sac_pkg::*; #(
    parameter int unsigned TW = TRQ_W,
    parameter int unsigned SW = SPD_W
) (
    // clock and reset
    input  wire logic                     i_clk,
    input  wire logic                     i_rstn,
    // host discrete inputs
    input  wire logic                     i_drive_enable_input,
    input  wire logic                     i_forward_torque_start,
    input  wire logic                     i_reverse_torque_start,
    input  wire logic                     i_alarm_clear_input,
    input  wire logic                     i_front_key_set,
    // analog side, already digitised
    input  wire logic [TW-1:0]            i_analog_torque_command,
    input  wire logic [TW-1:0]            i_torque_max_output,
    input  wire logic [TW-1:0]            i_torque_limit1,
    input  wire logic [N_SPD_LIM*SW-1:0]  i_speed_limits,
    input  wire logic [2:0]               i_speed_limit_sel,
    input  wire logic [15:0]              i_output_function,
    // internal status and fault causes
    input  wire sac_status_t              i_status,
    input  wire logic [N_ALARMS-1:0]      i_alarm_cause,
    input  wire logic [N_WARNINGS-1:0]    i_warning_cause,
    // host discrete outputs
    output logic                          o_fault_output,
    output logic [CODE_W-1:0]             o_status_pins,
    output logic                          o_warning,
    // drive command
    output logic [TW-1:0]                 o_torque_cmd,
    output logic [SW-1:0]                 o_speed_cap,
    output logic                          o_rotate_en,
    output logic                          o_motor_free,
    output sac_state_t                    o_state
);

    // the limit decode and the code tables below are written for these sizes
    if (TW != TRQ_W || SW != SPD_W) begin : width_check_g
        $error("sac_top: widths fixed by package");
    end
    if (N_SPD_LIM != 7 || CODE_W != 3) begin : table_check_g
        $error("sac_top: limit decode needs seven limits and 3-bit codes");
    end

    // ****************************************
    // alarm latch
    // ****************************************
    logic [N_ALARMS-1:0] latched;

    sac_latch #(
        .N (N_ALARMS)
    ) u_latch (
        .i_clk       (i_clk),
        .i_rstn      (i_rstn),
        .i_cause     (i_alarm_cause),
        .i_clr_key   (i_front_key_set),
        .i_clr_input (i_alarm_clear_input),
        .o_latched   (latched)
    );

    function automatic logic [CODE_W-1:0] pick_code(input logic [N_ALARMS-1:0] v);
        logic [CODE_W-1:0] c;
        c = CODE_RST;
        for (int k = N_ALARMS - 1; k >= 0; k--) begin
            if (v[k]) c = ALARM_CODES[k*CODE_W +: CODE_W];
        end
        return c;
    endfunction

    // ****************************************
    // helper functions
    // ****************************************
    // only one selector value routes the code; every other value keeps status
    function automatic logic code_selected(input logic [15:0] fn);
        return fn == OUTFN_CODE_SEL;
    endfunction

    // index 7 has no limit behind it and reads as zero, which stops rotation;
    // a case keeps the part-select from running past the limit vector
    function automatic logic [SW-1:0] pick_limit(
        input logic [N_SPD_LIM*SW-1:0] lims,
        input logic [2:0]              sel
    );
        logic [SW-1:0] v;
        v = '0;
        case (sel)
            3'h0:    v = lims[0*SW +: SW];
            3'h1:    v = lims[1*SW +: SW];
            3'h2:    v = lims[2*SW +: SW];
            3'h3:    v = lims[3*SW +: SW];
            3'h4:    v = lims[4*SW +: SW];
            3'h5:    v = lims[5*SW +: SW];
            3'h6:    v = lims[6*SW +: SW];
            default: v = '0;
        endcase
        return v;
    endfunction

    // full-scale command maps to the maximum-output setting; the whole product
    // is kept so that only the deliberate shift drops bits
    function automatic logic [TW-1:0] scale_torque(
        input logic [TW-1:0] cmd,
        input logic [TW-1:0] max_out
    );
        logic [2*TW-1:0] p;
        p = cmd * max_out;
        return p[2*TW-1 -: TW];
    endfunction

    // torque limit 1 is a hard ceiling on the scaled command
    function automatic logic [TW-1:0] cap_torque(
        input logic [TW-1:0] trq,
        input logic [TW-1:0] lim
    );
        logic [TW-1:0] v;
        v = trq;
        if (trq > lim) begin
            v = lim;
        end
        return v;
    endfunction

    // host pin order: bit 0 zero speed, bit 1 ready, bit 2 speed reached
    function automatic logic [CODE_W-1:0] status_view(input sac_status_t s);
        return {s.speed_reached, s.ready, s.zero_speed};
    endfunction

    // the code replaces the status view only while an alarm is latched and the
    // output function asks for it; warnings never reach this path
    function automatic logic [CODE_W-1:0] pins_view(
        input logic                sel,
        input logic [N_ALARMS-1:0] alarms,
        input sac_status_t         s
    );
        logic [CODE_W-1:0] v;
        v = status_view(s);
        if (sel && (alarms != '0)) begin
            v = pick_code(alarms);
        end
        return v;
    endfunction

    // each condition alone blocks rotation; the caller passes the next state
    // so that an alarm or a dropped enable stops the drive on the same edge
    function automatic logic may_rotate(
        input sac_state_t    st,
        input logic          start,
        input logic [TW-1:0] cmd,
        input logic [SW-1:0] lim,
        input logic [TW-1:0] tlim
    );
        logic ok;
        ok = (st == SAC_ST_RUN);
        ok = ok && start;
        ok = ok && (cmd != '0);
        ok = ok && (lim != '0);
        ok = ok && (tlim != '0);
        return ok;
    endfunction

    // an alarm always wins; leaving the fault state goes through off so that
    // the drive restarts only once enable is seen again
    function automatic sac_state_t next_state(
        input sac_state_t cur,
        input logic       alarm,
        input logic       enable
    );
        sac_state_t n;
        n = cur;
        case (cur)
            SAC_ST_OFF: begin
                if (alarm) begin
                    n = SAC_ST_FAULT;
                end else if (enable) begin
                    n = SAC_ST_RUN;
                end
            end
            SAC_ST_RUN: begin
                if (alarm) begin
                    n = SAC_ST_FAULT;
                end else if (!enable) begin
                    n = SAC_ST_OFF;
                end
            end
            SAC_ST_FAULT: begin
                if (!alarm) begin
                    n = SAC_ST_OFF;
                end
            end
            default: n = SAC_ST_OFF;
        endcase
        return n;
    endfunction

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        sac_state_t          st;
        logic                fault_out;
        logic [CODE_W-1:0]   pins;
        logic                warn;
        logic [TW-1:0]       torque;
        logic [SW-1:0]       spd;
        logic                rot;
        logic                free;
    } sac_top_st_t;

    sac_top_st_t st_reg;
    sac_top_st_t st_next;

    // ****************************************
    // next-state logic
    // ****************************************
    logic                alarm_any;
    logic                code_sel;
    logic [SW-1:0]       lim_sel;
    logic [TW-1:0]       trq_scaled;
    logic [TW-1:0]       trq_capped;
    logic                start_on;

    always_comb begin
        alarm_any  = |latched;
        code_sel   = code_selected(i_output_function);
        lim_sel    = pick_limit(i_speed_limits, i_speed_limit_sel);

        trq_scaled = scale_torque(i_analog_torque_command, i_torque_max_output);
        trq_capped = cap_torque(trq_scaled, i_torque_limit1);
        start_on   = i_forward_torque_start ^ i_reverse_torque_start;

        st_next           = st_reg;
        st_next.warn      = |i_warning_cause;
        st_next.fault_out = !alarm_any;
        // warnings never feed the pin view, only latched alarms do
        st_next.pins = pins_view(code_sel, latched, i_status);

        st_next.st   = next_state(st_reg.st, alarm_any, i_drive_enable_input);

        st_next.free = (st_next.st != SAC_ST_RUN);
        // zero command, zero limits or no start: command nothing
        st_next.rot  = may_rotate(st_next.st, start_on, i_analog_torque_command,
                                  lim_sel, i_torque_limit1);
        st_next.torque = st_next.rot ? trq_capped : '0;
        st_next.spd    = st_next.rot ? lim_sel : '0;
    end

    // ****************************************
    // registers
    // ****************************************
    // power-on view: fault output closed, shaft free, nothing commanded
    localparam sac_top_st_t ST_RESET = '{
        st:        SAC_ST_OFF,
        fault_out: 1'b1,
        pins:      CODE_RST,
        warn:      1'b0,
        torque:    '0,
        spd:       '0,
        rot:       1'b0,
        free:      1'b1
    };

    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            st_reg <= ST_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign o_fault_output = st_reg.fault_out;
    assign o_status_pins  = st_reg.pins;
    assign o_warning      = st_reg.warn;

    // ****************************************
    // drive outputs
    // ****************************************
    assign o_torque_cmd   = st_reg.torque;
    assign o_speed_cap    = st_reg.spd;
    assign o_rotate_en    = st_reg.rot;
    assign o_motor_free   = st_reg.free;
    assign o_state        = st_reg.st;

endmodule

// >>> bench/sac_props.sv
// Purpose: port-level checks on sac_top
// Assumes: one clock, async active-low reset
// Notes:   alarm path is two cycles, drive path one
module sac_props import sac_pkg::*; (
    // clock and reset
    input wire logic                  i_clk,
    input wire logic                  i_rstn,
    // inputs watched
    input wire logic                  i_drive_enable_input,
    input wire logic                  i_forward_torque_start,
    input wire logic                  i_reverse_torque_start,
    input wire logic [TRQ_W-1:0]      i_analog_torque_command,
    input wire logic [TRQ_W-1:0]      i_torque_limit1,
    input wire sac_status_t           i_status,
    input wire logic [N_ALARMS-1:0]   i_alarm_cause,
    input wire logic [N_WARNINGS-1:0] i_warning_cause,
    // outputs watched
    input wire logic                  o_fault_output,
    input wire logic [CODE_W-1:0]     o_status_pins,
    input wire logic                  o_warning,
    input wire logic                  o_rotate_en,
    input wire logic                  o_motor_free,
    input wire sac_state_t            o_state
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rstn);
    fault_on_alarm_a: assert property (|i_alarm_cause |-> ##2 !o_fault_output)
        else $error("fault output still closed during alarm");
    fault_stops_a: assert property (!o_fault_output |-> o_state == SAC_ST_FAULT
        && o_motor_free && !o_rotate_en) else $error("drive active while faulted");
    free_when_off_a: assert property (!i_drive_enable_input |=> o_motor_free)
        else $error("shaft held without drive enable");
    no_start_a: assert property (i_forward_torque_start == i_reverse_torque_start
        |=> !o_rotate_en) else $error("rotation without a single start");
    zero_cmd_a: assert property (i_analog_torque_command == '0 |=> !o_rotate_en)
        else $error("rotation with zero torque command");
    zero_limit_a: assert property (i_torque_limit1 == '0 |=> !o_rotate_en)
        else $error("rotation with zero torque limit");
    warn_set_a: assert property (|i_warning_cause |=> o_warning)
        else $error("warning not shown");
    warn_clear_a: assert property (i_warning_cause == '0 |=> !o_warning)
        else $error("warning not cleared");
    status_pass_a: assert property ($past(i_rstn) && o_fault_output |-> o_status_pins ==
        {$past(i_status.speed_reached), $past(i_status.ready), $past(i_status.zero_speed)})
        else $error("status pins lost while no alarm");
    alarm_c: cover property (!o_fault_output);
    rotate_c: cover property (o_rotate_en);
    warning_c: cover property (o_warning);
endmodule
bind sac_top sac_props chk_u (.i_clk, .i_rstn, .i_drive_enable_input, .i_forward_torque_start,
    .i_reverse_torque_start, .i_analog_torque_command, .i_torque_limit1, .i_status,
    .i_alarm_cause, .i_warning_cause, .o_fault_output, .o_status_pins, .o_warning,
    .o_rotate_en, .o_motor_free, .o_state);

// >>> bench/sac_host_model.sv
// Purpose: host controller driving drive enable
// Assumes: fault output high means closed
// Notes:   one edge of delay before enable drops
module sac_host_model (
    input  wire logic i_clk,
    input  wire logic i_rstn,
    input  wire logic i_fault_output,
    input  wire logic i_want_enable,
    output logic      o_drive_enable_input
);
    timeunit 1ns;
    timeprecision 1ps;
    always_ff @(posedge i_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            o_drive_enable_input <= 1'b0;
        end else begin
            o_drive_enable_input <= i_want_enable && i_fault_output;
        end
    end
endmodule

// >>> bench/testbench.sv
// Purpose: self-checking bench for sac_top
// Assumes: reads happen at the edge, before its updates land
// Notes:   drive enable comes through the host model
module testbench import sac_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [2:0] ctl;
        logic [11:0] c, m, l;
        logic [2:0] s;
        logic [1:0] rf;
        logic [11:0] trq;
    } sac_row_t;
    logic i_clk = 1'b0;
    logic i_rstn, want, i_forward_torque_start, i_reverse_torque_start;
    logic i_alarm_clear_input, i_front_key_set, i_drive_enable_input;
    logic o_fault_output, o_warning, o_rotate_en, o_motor_free;
    logic [TRQ_W-1:0] i_analog_torque_command, i_torque_max_output, i_torque_limit1;
    logic [TRQ_W-1:0] o_torque_cmd, o_speed_cap;
    logic [83:0] i_speed_limits;
    logic [2:0] i_speed_limit_sel, o_status_pins;
    logic [15:0] i_output_function;
    logic [N_ALARMS-1:0] i_alarm_cause;
    logic [N_WARNINGS-1:0] i_warning_cause;
    sac_status_t i_status;
    sac_state_t o_state;
    sac_row_t rw;
    int fails = 0, n_compared = 0;
    sac_row_t rows [11] = '{'{3'h6, 12'h800, 12'hFFF, 12'hFFF, 3'h0, 2'h2, 12'h7FF},
        '{3'h5, 12'h800, 12'h800, 12'hFFF, 3'h1, 2'h2, 12'h400},
        '{3'h6, 12'h800, 12'hFFF, 12'h100, 3'h0, 2'h2, 12'h100},
        '{3'h6, 12'hFFF, 12'h010, 12'hFFF, 3'h0, 2'h2, 12'h00F},
        '{3'h7, 12'h800, 12'hFFF, 12'hFFF, 3'h0, 2'h0, 12'h000},
        '{3'h4, 12'h800, 12'hFFF, 12'hFFF, 3'h0, 2'h0, 12'h000},
        '{3'h6, 12'h000, 12'hFFF, 12'hFFF, 3'h0, 2'h0, 12'h000},
        '{3'h6, 12'h800, 12'hFFF, 12'h000, 3'h0, 2'h0, 12'h000},
        '{3'h6, 12'h800, 12'hFFF, 12'hFFF, 3'h2, 2'h0, 12'h000},
        '{3'h6, 12'h800, 12'hFFF, 12'hFFF, 3'h7, 2'h0, 12'h000},
        '{3'h2, 12'h800, 12'hFFF, 12'hFFF, 3'h0, 2'h1, 12'h000}};
    sac_top dut_u (.i_clk, .i_rstn, .i_drive_enable_input, .i_forward_torque_start,
        .i_reverse_torque_start, .i_alarm_clear_input, .i_front_key_set,
        .i_analog_torque_command, .i_torque_max_output, .i_torque_limit1, .i_speed_limits,
        .i_speed_limit_sel, .i_output_function, .i_status, .i_alarm_cause, .i_warning_cause,
        .o_fault_output, .o_status_pins, .o_warning, .o_torque_cmd, .o_speed_cap,
        .o_rotate_en, .o_motor_free, .o_state);
    sac_host_model host_u (.i_clk, .i_rstn, .i_fault_output(o_fault_output),
        .i_want_enable(want), .o_drive_enable_input(i_drive_enable_input));
    always #10 i_clk = ~i_clk;
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic end_of_test;
        if (fails == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // a hang ends in a failed verdict instead of a missing one, so count it
    initial begin
        #20us;
        fails++;
        end_of_test();
    end
    initial begin
        {i_rstn, want, i_forward_torque_start, i_reverse_torque_start} = '0;
        {i_alarm_clear_input, i_front_key_set, i_speed_limit_sel, i_output_function} = '0;
        {i_analog_torque_command, i_torque_max_output, i_torque_limit1} = '0;
        {i_status, i_alarm_cause, i_warning_cause} = '0;
        i_speed_limits = 84'h700_600_500_400_000_200_100;
        repeat (2) @(posedge i_clk);
        check("rst_fault", o_fault_output, 1'b1);
        check("rst_free", o_motor_free, 1'b1);
        check("rst_state", o_state, SAC_ST_OFF);
        repeat (2) @(posedge i_clk);
        i_rstn <= 1'b1;
        foreach (rows[r]) begin
            @(posedge i_clk);
            rw = rows[r];
            {want, i_forward_torque_start, i_reverse_torque_start} <= rw.ctl;
            i_analog_torque_command <= rw.c;
            i_torque_max_output <= rw.m;
            i_torque_limit1 <= rw.l;
            i_speed_limit_sel <= rw.s;
            repeat (4) @(posedge i_clk);
            check("rotate", o_rotate_en, rw.rf[1]);
            check("free", o_motor_free, rw.rf[0]);
            if (rw.rf[1]) check("torque", o_torque_cmd, rw.trq);
            if (rw.rf[1]) check("speed", o_speed_cap, i_speed_limits[12*rw.s+:12]);
        end
        i_status <= 3'h4;
        i_output_function <= OUTFN_CODE_SEL;
        i_warning_cause <= 4'h1;
        repeat (3) @(posedge i_clk);
        check("warn_on", o_warning, 1'b1);
        check("warn_pins", o_status_pins, 3'h1);
        check("warn_fault", o_fault_output, 1'b1);
        i_warning_cause <= '0;
        repeat (3) @(posedge i_clk);
        check("warn_off", o_warning, 1'b0);
        for (int k = 0; k < 2; k++) begin
            i_alarm_cause[k] <= 1'b1;
            i_alarm_clear_input <= 1'b1;
            i_front_key_set <= 1'b1;
            repeat (4) @(posedge i_clk);
            check("fault", o_fault_output, 1'b0);
            check("code", o_status_pins, ALARM_CODES[3*k+:3]);
            i_output_function <= 16'h0000;
            repeat (3) @(posedge i_clk);
            check("unsel_pins", o_status_pins, 3'h1);
            i_output_function <= OUTFN_CODE_SEL;
            i_alarm_cause[k] <= 1'b0;
            repeat (4) @(posedge i_clk);
            check("cleared", o_fault_output, |(ALARM_CLR[3*k+:3] & 3'h6));
            i_alarm_clear_input <= 1'b0;
            i_front_key_set <= 1'b0;
            i_rstn <= 1'b0;
            @(posedge i_clk);
            i_rstn <= 1'b1;
            repeat (2) @(posedge i_clk);
            check("power_clr", o_fault_output, 1'b1);
        end
        end_of_test();
    end
endmodule
